// ===== cdr_chan.sv
// One channel: average, release baseline, delta capture and release exit.
`timescale 1ns/10ps
`default_nettype none
module cdr_chan
    import cdr_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Sample stream.
    input wire logic sample_i,
    input wire logic [CW-1:0] counts_i,
    input wire logic active_i,
    // Settings.
    input wire logic ltr_en_i,
    input wire logic [3:0] rel_beta_i,
    input wire logic [7:0] settle_thr_i,
    input wire logic [7:0] settle_cnt_i,
    input wire logic [7:0] exit_frac_i,
    // Follower correction, signed, applied while active.
    input wire logic corr_en_i,
    input wire logic signed [CW+1:0] corr_i,
    // State out.
    output logic [CW-1:0] lta_o,
    output logic [CW-1:0] rel_base_o,
    output logic [CW-1:0] delta_o,
    output logic release_o
);
    logic [7:0] settle_r;
    logic captured_r;
    logic [CW+3:0] rel_acc_r;
    logic [CW-1:0] rel_diff;
    logic signed [CW+1:0] lta_adj;
    logic [CW+7:0] exit_lvl;
    logic above;

    assign above = counts_i > rel_base_o;
    assign rel_diff = above ? counts_i - rel_base_o : rel_base_o - counts_i;
    assign exit_lvl = (CW+8)'(delta_o) * (CW+8)'(exit_frac_i);
    // Exit once counts rise past the captured fraction.
    assign release_o = ltr_en_i && active_i && captured_r && above
        && ((CW+8)'(rel_diff) << FRAC_SHIFT) > exit_lvl;
    assign lta_adj = $signed({2'b00, lta_o}) - corr_i;

    ////////////////////////////////////////////////////////////////////////////
    // Long term average freezes while active, except for the follower drift term and the reseed to counts on release.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lta_o <= '0;
        end else if (sample_i) begin
            if (release_o) begin
                lta_o <= counts_i;
            end else if (!active_i) begin
                lta_o <= CW'(lta_o + ((counts_i >> LTA_BETA_SHIFT) - (lta_o >> LTA_BETA_SHIFT)));
            end else if (corr_en_i) begin
                lta_o <= lta_adj < 0 ? '0 : CW'(lta_adj);
            end
        end
    end

    // Release baseline runs every sample, touch or not; held to counts when off.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rel_acc_r <= '0;
        end else if (sample_i) begin
            if (!ltr_en_i || release_o) begin
                rel_acc_r <= {counts_i, 4'h0};
            end else begin
                rel_acc_r <= (CW+4)'(rel_acc_r + ({counts_i, 4'h0} >> rel_beta_i)
                    - (rel_acc_r >> rel_beta_i));
            end
        end
    end
    assign rel_base_o = rel_acc_r[CW+3:4];

    // Settle counter and captured delta.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            settle_r <= '0;
            captured_r <= 1'b0;
            delta_o <= '0;
        end else if (sample_i) begin
            if (!ltr_en_i || !active_i || release_o) begin
                settle_r <= '0;
                captured_r <= 1'b0;
            end else if (rel_diff < CW'(settle_thr_i)) begin
                if (settle_r > settle_cnt_i) begin
                    captured_r <= 1'b1;
                    if (!captured_r) begin
                        delta_o <= counts_i > lta_o ? counts_i - lta_o : lta_o - counts_i;
                    end
                end else begin
                    settle_r <= settle_r + 8'h01;
                end
            end else begin
                settle_r <= '0;
            end
        end
    end
endmodule : cdr_chan
`default_nettype wire

// ===== cdr_pkg.sv
// Package of constants and types for the channel drift and release block.
//
// What this block does
// - Each channel is independent, reference or follower, chosen by its role setting.
// - A follower's ref select names the channel whose baseline changes it tracks.
// - A reference blocks auto tuning while any masked status prox/touch flag is set.
// - Mask used only for reference role; ref select ignored in reference role.
// - Mask bits 0 and 1 pick channel 0 prox and touch; 0x03 picks both.
// - Follower scales reference adjustment by gain over 4096; 4096 tracks one to one.
// - In prox or touch, follower average drops by reference average change.
// - With long touch release on, release baseline updates every sample and is readable.
// - Release baseline is an IIR beta filter with its own beta setting.
// - In prox or touch the long term average freezes except for follower drift and release reseed; release baseline keeps updating.
// - After settling past the count, store abs(average minus counts) as captured delta.
// - A fraction of captured delta set by exit fraction is the exit criterion.
// - Counts minus baseline above delta times fraction over 128 reseeds and exits states.
// - Long touch release works only when its enable bit is set.
package cdr_pkg;
    localparam int NCH = 3;
    localparam int CW = 16;
    localparam int GAIN_W = 16;
    localparam int GAIN_SHIFT = 12;
    localparam int FRAC_SHIFT = 7;
    localparam int MASK_W = 6;
    // APB register map, one word per register, a 0x20 byte block per channel register group.
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_SYS_STATUS = 12'h004;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h008;
    localparam logic [11:0] OFS_IRQ_CLEAR = 12'h00C;
    localparam logic [11:0] OFS_IRQ_ENABLE = 12'h010;
    localparam logic [11:0] OFS_CH_BASE = 12'h040;
    localparam logic [11:0] OFS_CH_STRIDE = 12'h020;
    localparam logic [4:0] CH_SETUP = 5'h00;
    localparam logic [4:0] CH_GAIN = 5'h04;
    localparam logic [4:0] CH_RELCFG = 5'h08;
    localparam logic [4:0] CH_LTA = 5'h0C;
    localparam logic [4:0] CH_RELBASE = 5'h10;
    localparam logic [4:0] CH_DELTA = 5'h14;
    localparam logic [4:0] CH_COUNTS = 5'h18;
    localparam logic [31:0] CH_SETUP_RST = 32'h0000_0000;
    localparam logic [31:0] CH_GAIN_RST = 32'h0000_1000;
    localparam logic [31:0] CH_RELCFG_RST = 32'h0040_0404;
    localparam int LTA_BETA_SHIFT = 4;
    typedef enum logic [1:0] {CDR_INDEP, CDR_REF, CDR_FOLLOW} cdr_role_t;
endpackage : cdr_pkg

// ===== cdr_top.sv
// Top of the channel drift and release block with its APB register file.
`timescale 1ns/10ps
`default_nettype none
module cdr_top
    import cdr_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Sensing front end, same clock.
    input wire logic sample_i,
    input wire logic [NCH*CW-1:0] counts_i,
    input wire logic [NCH-1:0] prox_i,
    input wire logic [NCH-1:0] touch_i,
    // Tuning and release outputs.
    output logic [NCH-1:0] tune_block_o,
    output logic [NCH-1:0] reseed_o,
    output logic irq_o
);
    logic [31:0] setup_r [NCH];
    logic [31:0] gain_r [NCH];
    logic [31:0] relcfg_r [NCH];
    logic [NCH-1:0] irq_stat_r;
    logic [NCH-1:0] irq_en_r;
    logic [NCH-1:0] ltr_en_r;
    logic [CW-1:0] long_term_average [NCH];
    logic [CW-1:0] relb [NCH];
    logic [CW-1:0] dlt [NCH];
    logic [CW-1:0] lta_prev_r [NCH];
    logic signed [CW+1:0] corr [NCH];
    logic [NCH-1:0] corr_en;
    logic [NCH-1:0] active;
    logic [15:0] sys_status;
    logic wr_en;
    logic [31:0] rd_mux;
    logic ch_hit;
    logic [1:0] ch_idx;
    logic [4:0] ch_reg;

    // Upper byte holds prox/touch pairs per channel.
    always_comb begin
        sys_status = '0;
        for (int c = 0; c < NCH; c++) begin
            sys_status[8+2*c] = prox_i[c];
            sys_status[9+2*c] = touch_i[c];
        end
    end
    assign active = prox_i | touch_i;

    function automatic cdr_role_t role_of(input logic [31:0] s);
        return cdr_role_t'(s[1:0]);
    endfunction : role_of

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel logic.
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        logic [1:0] rsel;
        logic signed [CW:0] ref_chg;
        logic signed [CW+GAIN_W+1:0] prod;
        assign rsel = setup_r[g][5:4];
        assign ref_chg = $signed({1'b0, long_term_average[rsel]}) - $signed({1'b0, lta_prev_r[rsel]});
        assign prod = (CW+GAIN_W+2)'(ref_chg) * $signed({2'b00, gain_r[g][GAIN_W-1:0]});
        assign corr[g] = (CW+2)'(prod >>> GAIN_SHIFT);
        // Ref select is only read in the follower role.
        assign corr_en[g] = role_of(setup_r[g]) == CDR_FOLLOW && active[g]
            && rsel != 2'(g) && rsel < 2'(NCH);
        // Mask is only read in the reference role.
        assign tune_block_o[g] = role_of(setup_r[g]) == CDR_REF
            && |(setup_r[g][8+MASK_W-1:8] & sys_status[8+MASK_W-1:8]);
        assign ltr_en_r[g] = setup_r[g][16];

        always_ff @(posedge ref_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                lta_prev_r[g] <= '0;
            end else if (sample_i) begin
                lta_prev_r[g] <= long_term_average[g];
            end
        end

        cdr_chan u_chan (
            .ref_clk_i(ref_clk_i),
            .rstn_i(rstn_i),
            .sample_i(sample_i),
            .counts_i(counts_i[g*CW +: CW]),
            .active_i(active[g]),
            .ltr_en_i(ltr_en_r[g]),
            .rel_beta_i(relcfg_r[g][3:0]),
            .settle_thr_i(relcfg_r[g][15:8]),
            .settle_cnt_i(relcfg_r[g][23:16]),
            .exit_frac_i(relcfg_r[g][31:24]),
            .corr_en_i(corr_en[g]),
            .corr_i(corr[g]),
            .lta_o(long_term_average[g]),
            .rel_base_o(relb[g]),
            .delta_o(dlt[g]),
            .release_o(reseed_o[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, error on unmapped addresses.
    assign pready_o = 1'b1;
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign ch_hit = paddr_i >= OFS_CH_BASE && paddr_i < OFS_CH_BASE + 12'(NCH) * OFS_CH_STRIDE;
    assign ch_idx = 2'((paddr_i - OFS_CH_BASE) >> 5);
    assign ch_reg = paddr_i[4:0];

    always_comb begin
        rd_mux = '0;
        pslverr_o = 1'b0;
        if (ch_hit) begin
            case (ch_reg)
                CH_SETUP: rd_mux = setup_r[ch_idx];
                CH_GAIN: rd_mux = gain_r[ch_idx];
                CH_RELCFG: rd_mux = relcfg_r[ch_idx];
                CH_LTA: rd_mux = {16'h0000, long_term_average[ch_idx]};
                CH_RELBASE: rd_mux = {16'h0000, relb[ch_idx]};
                CH_DELTA: rd_mux = {16'h0000, dlt[ch_idx]};
                CH_COUNTS: rd_mux = {16'h0000, counts_i[ch_idx*CW +: CW]};
                default: pslverr_o = psel_i && penable_i;
            endcase
        end else begin
            case (paddr_i)
                OFS_CTRL: rd_mux = '0;
                OFS_SYS_STATUS: rd_mux = {16'h0000, sys_status};
                OFS_IRQ_STATUS: rd_mux = {29'h0, irq_stat_r};
                OFS_IRQ_CLEAR: rd_mux = '0;
                OFS_IRQ_ENABLE: rd_mux = {29'h0, irq_en_r};
                default: pslverr_o = psel_i && penable_i;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o <= '0;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= rd_mux;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int c = 0; c < NCH; c++) begin
                setup_r[c] <= CH_SETUP_RST;
                gain_r[c] <= CH_GAIN_RST;
                relcfg_r[c] <= CH_RELCFG_RST;
            end
            irq_en_r <= '0;
        end else if (wr_en) begin
            if (ch_hit && ch_reg == CH_SETUP) setup_r[ch_idx] <= pwdata_i;
            if (ch_hit && ch_reg == CH_GAIN) gain_r[ch_idx] <= pwdata_i;
            if (ch_hit && ch_reg == CH_RELCFG) relcfg_r[ch_idx] <= pwdata_i;
            if (!ch_hit && paddr_i == OFS_IRQ_ENABLE) irq_en_r <= pwdata_i[NCH-1:0];
        end
    end

    // Release events are sticky; a set in the clearing cycle wins.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~((wr_en && !ch_hit && paddr_i == OFS_IRQ_CLEAR)
                ? pwdata_i[NCH-1:0] : '0)) | (reseed_o & {NCH{sample_i}});
        end
    end
    assign irq_o = |(irq_stat_r & irq_en_r);
endmodule : cdr_top
`default_nettype wire

// ===== cdr_top_monitor.sv
// Port checker for the channel drift and release block.
`timescale 1ns/10ps
`default_nettype none
module cdr_top_monitor
    import cdr_pkg::*;
(
    // Watched ports.
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic sample_i,
    input wire logic [NCH*CW-1:0] counts_i,
    input wire logic [NCH-1:0] prox_i,
    input wire logic [NCH-1:0] touch_i,
    input wire logic [NCH-1:0] tune_block_o,
    input wire logic [NCH-1:0] reseed_o,
    input wire logic irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    logic wr_q;
    logic smp_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Register state only moves on the edge after a write or a sample.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_q <= 1'b0;
            smp_q <= 1'b0;
        end else begin
            wr_q <= psel_i && penable_i && pwrite_i;
            smp_q <= sample_i;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    ready_high_a: assert property (psel_i && penable_i |-> pready_o) else $error("no ready");
    err_access_a: assert property (pslverr_o |-> psel_i && penable_i) else $error("stray err");
    map_ok_a: assert property (psel_i && penable_i && paddr_i == OFS_IRQ_ENABLE |-> !pslverr_o)
        else $error("err on mapped");
    rdata_hold_a: assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
        else $error("read data moved");
    tune_idle_a: assert property (prox_i == 3'h0 && touch_i == 3'h0 |-> tune_block_o == 3'h0)
        else $error("tuning blocked idle");
    tune_cause_a: assert property ($stable(prox_i) && $stable(touch_i) && !wr_q |->
        $stable(tune_block_o)) else $error("tune block moved");
    irq_cause_a: assert property (!wr_q && !smp_q |-> $stable(irq_o))
        else $error("irq moved");
    reseed_cause_a: assert property (!wr_q && !smp_q && $stable(counts_i) && $stable(prox_i)
        && $stable(touch_i) |-> $stable(reseed_o)) else $error("reseed moved");
endmodule : cdr_top_monitor
bind cdr_top cdr_top_monitor u_cdr_top_monitor (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sample_i(sample_i),
    .counts_i(counts_i), .prox_i(prox_i), .touch_i(touch_i), .tune_block_o(tune_block_o),
    .reseed_o(reseed_o), .irq_o(irq_o));
`default_nettype wire

// ===== cdr_top_tb_top.sv
// Directed testbench for the channel drift and release block.
`timescale 1ns/10ps
`default_nettype none
module cdr_top_tb_top
    import cdr_pkg::*;
;
    logic ref_clk_i = 1'b0, rstn_i = 1'b0, sample_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [NCH*CW-1:0] counts_i = 48'h1000_1000_1000;
    logic [NCH-1:0] prox_i = 3'h0, touch_i = 3'h0, tune_block_o, reseed_o;
    logic [31:0] prdata_o, rd;
    logic pready_o, pslverr_o, irq_o, err;
    int miscompares = 0, num_checks = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    cdr_top u_cdr_top (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sample_i(sample_i),
        .counts_i(counts_i), .prox_i(prox_i), .touch_i(touch_i), .tune_block_o(tune_block_o),
        .reseed_o(reseed_o), .irq_o(irq_o));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    // Each transfer starts one edge after the caller, so releases never collide.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        @(posedge ref_clk_i);
        while (pready_o !== 1'b1) @(posedge ref_clk_i);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic smp(input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            sample_i <= 1'b1;
            @(posedge ref_clk_i);
            sample_i <= 1'b0;
        end
    endtask : smp
    function automatic logic [11:0] ca(input int c, input logic [4:0] o);
        return OFS_CH_BASE + OFS_CH_STRIDE * 12'(c) + {7'h00, o};
    endfunction : ca
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        miscompares++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        for (int c = 0; c < NCH; c++) begin
            apb(1'b0, ca(c, CH_SETUP), 32'h0);
            chk(rd, CH_SETUP_RST, "setup");
            apb(1'b0, ca(c, CH_GAIN), 32'h0);
            chk(rd, 32'h0000_1000, "gain");
            apb(1'b0, ca(c, CH_RELCFG), 32'h0);
            chk(rd, CH_RELCFG_RST, "relcfg");
        end
        apb(1'b0, 12'hFF0, 32'h0);
        chk({rd[30:0], err}, 32'h1, "unmapped");
        apb(1'b0, ca(1, CH_COUNTS), 32'h0);
        chk(rd, 32'h0000_1000, "counts");
        // Channel 1 is the reference; its ref select field is set but must not matter.
        apb(1'b1, ca(1, CH_SETUP), 32'h0000_0331);
        for (int k = 0; k < 6; k++) begin
            prox_i <= 3'(k % 2 == 0) << (k / 2);
            touch_i <= 3'(k % 2) << (k / 2);
            apb(1'b0, OFS_SYS_STATUS, 32'h0);
            chk(rd & 32'h0000_3F00, 32'h0000_0100 << k, "status");
            chk(32'(tune_block_o), 32'(k < 2) << 1, "tune block");
        end
        apb(1'b1, ca(1, CH_SETUP), 32'h0000_0302);
        prox_i <= 3'h1;
        touch_i <= 3'h0;
        apb(1'b0, ca(1, CH_SETUP), 32'h0);
        chk(32'(tune_block_o), 32'h0, "follower mask");
        prox_i <= 3'h0;
        apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_0007);
        for (int c = 0; c < NCH; c++) apb(1'b1, ca(c, CH_RELCFG), 32'hFF02_FF04);
        // Enough samples for the average to land exactly on flat counts; the
        // release baseline is held on the counts while the feature is off.
        smp(120);
        apb(1'b0, ca(2, CH_LTA), 32'h0);
        chk(rd, 32'h0000_1000, "avg settled");
        apb(1'b1, ca(2, CH_SETUP), 32'h0001_0000);
        prox_i <= 3'h5;
        counts_i <= 48'h1040_1000_1040;
        smp(1);
        apb(1'b0, ca(2, CH_RELBASE), 32'h0);
        chk(rd, 32'h0000_1004, "relbase moves");
        apb(1'b0, ca(0, CH_RELBASE), 32'h0);
        chk(rd, 32'h0000_1040, "relbase off");
        smp(4);
        apb(1'b0, ca(2, CH_LTA), 32'h0);
        chk(rd, 32'h0000_1000, "avg frozen");
        apb(1'b0, ca(2, CH_DELTA), 32'h0);
        chk(rd, 32'h0000_0040, "captured");
        counts_i <= 48'h5040_1000_5040;
        @(posedge ref_clk_i);
        #1;
        chk(32'(reseed_o), 32'h4, "reseed level");
        smp(2);
        #1;
        chk(32'(irq_o), 32'h1, "irq raised");
        apb(1'b0, ca(2, CH_LTA), 32'h0);
        chk(rd, 32'h0000_5040, "reseeded");
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        chk(rd, 32'h0000_0004, "release events");
        apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_0003);
        #1;
        chk(32'(irq_o), 32'h0, "irq masked");
        apb(1'b1, OFS_IRQ_CLEAR, 32'h0000_0004);
        apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_0007);
        #1;
        chk(32'(irq_o), 32'h0, "irq cleared");
        // Channel 0 follows channel 1 at twice unity gain while in proximity.
        apb(1'b1, ca(1, CH_SETUP), 32'h0000_0301);
        #1;
        chk(32'(tune_block_o), 32'h2, "ref blocked");
        apb(1'b1, ca(0, CH_GAIN), 32'h0000_2000);
        apb(1'b1, ca(0, CH_SETUP), 32'h0000_0012);
        counts_i <= 48'h5040_1100_5040;
        smp(2);
        apb(1'b0, ca(0, CH_LTA), 32'h0);
        chk(rd, 32'h0000_0FE0, "follower drift");
        close_out();
    end
endmodule : cdr_top_tb_top
`default_nettype wire
